// ---- design/los_detector.sv ----
// one channel of digital receive loss of signal detection
`default_nettype none
module los_detector
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// received bit stream
	input wire logic bit_en_i,
	input wire logic bit_one_i,
	input wire logic analog_loss_i,
	// configuration
	input wire logic enable_i,
	input wire los_mclk_pkg::los_cfg_t cfg_i,
	// results
	output logic loss_o,
	output logic declare_o
);
	logic [los_mclk_pkg::ZC_W-1:0] zero_r; // consecutive zeros, saturating
	logic [los_mclk_pkg::WIN_W-1:0] win_pos_r; // position in window
	logic [los_mclk_pkg::WIN_W-1:0] ones_r; // ones so far in window
	logic run_bad_r; // window saw too long a zero run
	logic win_ok_r; // last window passed density check
	los_mclk_pkg::los_state_t state_r;
	logic [los_mclk_pkg::ZC_W-1:0] thr; // declare threshold
	logic [los_mclk_pkg::ZC_W-1:0] max_run; // clear run limit
	logic [los_mclk_pkg::WIN_W-1:0] win_last; // window end
	logic [los_mclk_pkg::WIN_W-1:0] min_ones; // ones needed
	logic [los_mclk_pkg::WIN_W-1:0] ones_nxt;
	logic win_end;

	// ==========================================================
	// rate dependent figures
	always_comb
	begin
		if (cfg_i.t1_mode)
		begin
			thr = los_mclk_pkg::T1_LOS_ZEROS;
			max_run = los_mclk_pkg::T1_MAX_RUN;
			win_last = los_mclk_pkg::T1_WIN_LAST;
			min_ones = los_mclk_pkg::T1_MIN_ONES;
		end
		else
		begin
			thr = cfg_i.extended_loss_enable ?
				los_mclk_pkg::E1_EXT_LOS_ZEROS :
				los_mclk_pkg::E1_LOS_ZEROS;
			max_run = los_mclk_pkg::E1_MAX_RUN;
			win_last = los_mclk_pkg::E1_WIN_LAST;
			min_ones = los_mclk_pkg::E1_MIN_ONES;
		end
	end

	assign ones_nxt = ones_r + los_mclk_pkg::WIN_W'(bit_one_i);
	assign win_end = bit_en_i && (win_pos_r >= win_last);

	// ==========================================================
	// zero run counter, cleared by any one
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			zero_r <= '0;
		else if (!enable_i || (bit_en_i && bit_one_i) ||
			!(analog_loss_i || loss_o))
			zero_r <= '0;
		else if (bit_en_i && zero_r != '1)
			zero_r <= zero_r + 1'b1;
	end

	// ==========================================================
	// ones density window, one bit per recovered clock
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			win_pos_r <= '0;
			ones_r <= '0;
			run_bad_r <= 1'b0;
			win_ok_r <= 1'b0;
		end
		else if (!enable_i)
		begin
			win_pos_r <= '0;
			ones_r <= '0;
			run_bad_r <= 1'b0;
			win_ok_r <= 1'b0;
		end
		else if (win_end)
		begin
			// judge the closed window and start the next one
			win_ok_r <= (ones_nxt >= min_ones) && !run_bad_r;
			win_pos_r <= '0;
			ones_r <= '0;
			run_bad_r <= 1'b0;
		end
		else if (bit_en_i)
		begin
			win_pos_r <= win_pos_r + 1'b1;
			ones_r <= ones_nxt;
			if (!bit_one_i && zero_r >= max_run)
				run_bad_r <= 1'b1; // run passes the limit
		end
	end

	// ==========================================================
	// declare and clear decisions
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= los_mclk_pkg::LOS_CLEAR;
			declare_o <= 1'b0;
		end
		else
		begin
			declare_o <= 1'b0;
			case (state_r)
				los_mclk_pkg::LOS_CLEAR:
					// zeros only count once the analog side flags loss
					if (enable_i && analog_loss_i && zero_r >= thr)
					begin
						state_r <= los_mclk_pkg::LOS_DECLARED;
						declare_o <= 1'b1;
					end
				los_mclk_pkg::LOS_DECLARED:
					if (!enable_i)
						state_r <= los_mclk_pkg::LOS_CLEAR;
					else if (!analog_loss_i && win_ok_r)
						state_r <= los_mclk_pkg::LOS_CLEAR;
				default:
					state_r <= los_mclk_pkg::LOS_CLEAR;
			endcase
		end
	end

	assign loss_o = (state_r == los_mclk_pkg::LOS_DECLARED);
endmodule
`default_nettype wire

// ---- design/los_mclk_pkg.sv ----
// shared constants, types and register map for the loss and master clock block
`default_nettype none
package los_mclk_pkg;
	// ==========================================================
	// clocking
	localparam longint unsigned CLK_HZ = 125_000_000; // system clock rate
	localparam longint unsigned E1_MCLK_HZ = 2_048_000; // e1 master clock
	localparam longint unsigned T1_MCLK_HZ = 1_544_000; // t1 master clock
	localparam int NCO_W = 32; // phase accumulator width
	localparam logic [NCO_W-1:0] E1_NCO_INC =
		NCO_W'((E1_MCLK_HZ << NCO_W) / CLK_HZ);
	localparam logic [NCO_W-1:0] T1_NCO_INC =
		NCO_W'((T1_MCLK_HZ << NCO_W) / CLK_HZ);
	localparam int NCH = 8; // channel count
	localparam int REF_CNT_W = 16; // reference edge counter width

	// ==========================================================
	// loss of signal thresholds
	localparam int ZC_W = 13; // zero counter width
	localparam logic [ZC_W-1:0] E1_LOS_ZEROS = 13'h0020; // 32
	localparam logic [ZC_W-1:0] E1_EXT_LOS_ZEROS = 13'h1000; // 4096
	localparam logic [ZC_W-1:0] T1_LOS_ZEROS = 13'h00AF; // 175
	localparam logic [ZC_W-1:0] E1_MAX_RUN = 13'h0010; // 16
	localparam logic [ZC_W-1:0] T1_MAX_RUN = 13'h0064; // 100
	localparam int WIN_W = 8; // window position width
	localparam logic [WIN_W-1:0] E1_WIN_LAST = 8'h1F; // 32 bit window
	localparam logic [WIN_W-1:0] T1_WIN_LAST = 8'h7F; // 128 bit window
	localparam logic [WIN_W-1:0] E1_MIN_ONES = 8'h04; // 4 ones
	localparam logic [WIN_W-1:0] T1_MIN_ONES = 8'h10; // 16 ones

	// ==========================================================
	// register map (byte addresses)
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] LOS_OFS = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	localparam logic [11:0] MASK_OFS = 12'h00C;
	localparam logic [11:0] REF_OFS = 12'h010;
	localparam logic [8:0] CTRL_RST = 9'h002; // receivers on, e1, 2048

	// control register layout, bit 8 downward
	typedef struct packed {
		logic decode_en; // bit 8: line code decoder on
		logic t1_mode; // bit 7: t1 or j1 line rate
		logic extended_loss_enable; // bit 6
		logic master_rate_select; // bit 5
		logic [2:0] ref_freq_select; // bits 4:2
		logic receiver_on_all; // bit 1
		logic host_mode; // bit 0
	} ctrl_t;

	// settings handed to each loss detector
	typedef struct packed {
		logic t1_mode;
		logic extended_loss_enable;
	} los_cfg_t;

	// loss detector states
	typedef enum logic {LOS_CLEAR, LOS_DECLARED} los_state_t;

	// reference select codes
	localparam logic [2:0] REF_DIRECT_E1 = 3'h0;
	localparam logic [2:0] REF_DIRECT_T1 = 3'h1;
endpackage
`default_nettype wire

// ---- design/mclk_synth.sv ----
// master clock tick synthesiser with reference edge monitor
`default_nettype none
module mclk_synth
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// synchronised reference inputs
	input wire logic e1_ref_i,
	input wire logic t1_ref_i,
	// selection
	input wire logic [2:0] ref_freq_select_i,
	input wire logic master_rate_select_i,
	// results
	output logic master_tick_o,
	output logic [los_mclk_pkg::REF_CNT_W-1:0] ref_edges_o
);
	logic [los_mclk_pkg::NCO_W-1:0] phase_r; // accumulator
	logic [los_mclk_pkg::NCO_W:0] phase_sum;
	logic ref_sel; // chosen reference level
	logic ref_d_r; // delayed reference for edge detection

	// ==========================================================
	// reference choice: only direct 1544 uses the t1 input
	always_comb
	begin
		if (ref_freq_select_i == los_mclk_pkg::REF_DIRECT_T1)
			ref_sel = t1_ref_i;
		else
			ref_sel = e1_ref_i;
	end

	// output rate follows the rate bit for every code
	assign phase_sum = {1'b0, phase_r} + {1'b0, master_rate_select_i ?
		los_mclk_pkg::T1_NCO_INC : los_mclk_pkg::E1_NCO_INC};

	// ==========================================================
	// accumulator carry gives one tick per master clock period
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_r <= '0;
			master_tick_o <= 1'b0;
		end
		else
		begin
			phase_r <= phase_sum[los_mclk_pkg::NCO_W-1:0];
			master_tick_o <= phase_sum[los_mclk_pkg::NCO_W];
		end
	end

	// ==========================================================
	// count rising reference edges so software sees the source live
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ref_d_r <= 1'b0;
			ref_edges_o <= '0;
		end
		else
		begin
			ref_d_r <= ref_sel;
			if (ref_sel && !ref_d_r)
				ref_edges_o <= ref_edges_o + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- design/rx_los_and_mclk_select.sv ----
// top: pin and register control, loss detection and interrupt for 8 channels
// ==========================================================
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none
module rx_los_and_mclk_select
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// hardware control pins
	input wire logic host_mode_i,
	input wire logic receiver_on_all_i,
	input wire logic [2:0] ref_freq_select_i,
	input wire logic master_rate_select_i,
	// master clock references
	input wire logic e1_ref_clock_in_i,
	input wire logic t1_ref_clock_in_i,
	// per channel recovered stream from the front end
	input wire logic [7:0] rx_clk_i,
	input wire logic [7:0] rx_pos_i,
	input wire logic [7:0] rx_neg_i,
	input wire logic [7:0] analog_loss_i,
	// per channel results
	output logic [7:0] rx_pos_or_data_out_o,
	output logic [7:0] rx_neg_or_violation_out_o,
	output logic [7:0] rx_loss_of_signal_o,
	output logic [7:0] receiver_enable_o,
	// master clock and interrupt
	output logic master_tick_o,
	output logic int_n_o
);
	// ==========================================================
	// pin synchroniser widths
	localparam int PIN_W = 6 + 4 * los_mclk_pkg::NCH;

	logic [PIN_W-1:0] pin_raw; // pins as they arrive
	logic [PIN_W-1:0] meta_r; // first stage, read only by second
	logic [PIN_W-1:0] sync_r; // second stage, safe to use
	logic [los_mclk_pkg::NCH-1:0] rxclk_d_r; // previous recovered clock
	logic [los_mclk_pkg::NCH-1:0] bit_en; // one pulse per received bit
	logic [los_mclk_pkg::NCH-1:0] s_rxclk;
	logic [los_mclk_pkg::NCH-1:0] s_pos;
	logic [los_mclk_pkg::NCH-1:0] s_neg;
	logic [los_mclk_pkg::NCH-1:0] s_aloss;
	logic s_host, s_receiver_on_all, s_rate, s_e1ref, s_t1ref;
	logic [2:0] s_refsel;

	// register state
	los_mclk_pkg::ctrl_t ctrl_r; // control register
	logic [los_mclk_pkg::NCH-1:0] stat_r; // sticky loss events
	logic [los_mclk_pkg::NCH-1:0] mask_r; // interrupt enables
	logic [los_mclk_pkg::NCH-1:0] stat_nxt;

	// effective settings after host or hardware choice
	logic rx_on; // receivers enabled
	logic [2:0] eff_refsel;
	logic eff_rate;
	los_mclk_pkg::los_cfg_t los_cfg;

	// detector outputs
	logic [los_mclk_pkg::NCH-1:0] loss;
	logic [los_mclk_pkg::NCH-1:0] declare;
	logic [los_mclk_pkg::REF_CNT_W-1:0] ref_edges;

	// bus decode
	logic acc; // access phase of a transfer
	logic wr_acc;
	logic rd_acc;
	logic hit; // address is mapped

	// ==========================================================
	// gather every asynchronous pin but the upper select bits into one synchroniser
	assign pin_raw = {host_mode_i, receiver_on_all_i, master_rate_select_i,
		e1_ref_clock_in_i, t1_ref_clock_in_i, ref_freq_select_i[0],
		rx_clk_i, rx_pos_i, rx_neg_i, analog_loss_i};

	// two flip-flops per pin before any logic looks at it
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= pin_raw;
			sync_r <= meta_r;
		end
	end

	// the upper select bits ride their own pair of stages
	logic [1:0] refsel_meta_r;
	logic [1:0] refsel_sync_r;

	// second synchroniser for the remaining select bits
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			refsel_meta_r <= '0;
			refsel_sync_r <= '0;
		end
		else
		begin
			refsel_meta_r <= ref_freq_select_i[2:1];
			refsel_sync_r <= refsel_meta_r;
		end
	end

	// unpack the synchronised pins
	assign {s_host, s_receiver_on_all, s_rate, s_e1ref, s_t1ref, s_refsel[0],
		s_rxclk, s_pos, s_neg, s_aloss} = sync_r;
	assign s_refsel[2:1] = refsel_sync_r;

	// ==========================================================
	// recovered clock rising edge marks each received bit
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rxclk_d_r <= '0;
		else
			rxclk_d_r <= s_rxclk;
	end

	assign bit_en = s_rxclk & ~rxclk_d_r;

	// ==========================================================
	// host mode takes selects from the register, else from the pins
	always_comb
	begin
		if (s_host)
		begin
			rx_on = ctrl_r.receiver_on_all;
			eff_refsel = ctrl_r.ref_freq_select;
			eff_rate = ctrl_r.master_rate_select;
		end
		else
		begin
			rx_on = s_receiver_on_all;
			eff_refsel = s_refsel;
			eff_rate = s_rate;
		end
	end

	// one line rate for all channels, so one shared configuration
	assign los_cfg.t1_mode = ctrl_r.t1_mode;
	assign los_cfg.extended_loss_enable = ctrl_r.extended_loss_enable;
	assign receiver_enable_o = {los_mclk_pkg::NCH{rx_on}};

	// ==========================================================
	// master clock synthesis from the system clock, plus an edge count of the selected reference
	mclk_synth u_mclk
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.e1_ref_i(s_e1ref),
		.t1_ref_i(s_t1ref),
		.ref_freq_select_i(eff_refsel),
		.master_rate_select_i(eff_rate),
		.master_tick_o(master_tick_o),
		.ref_edges_o(ref_edges)
	);

	// ==========================================================
	// one loss detector per channel
	genvar ch;
	generate
		for (ch = 0; ch < los_mclk_pkg::NCH; ch++)
		begin : g_ch
			los_detector u_los
			(
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.bit_en_i(bit_en[ch]),
				.bit_one_i(s_pos[ch] | s_neg[ch]),
				.analog_loss_i(s_aloss[ch]),
				.enable_i(rx_on),
				.cfg_i(los_cfg),
				.loss_o(loss[ch]),
				.declare_o(declare[ch])
			);
		end
	endgenerate

	// loss level is shown on its own pins
	assign rx_loss_of_signal_o = loss;

	// ==========================================================
	// receive data outputs, updated once per received bit
	// the decoder here only folds rails and flags a double mark;
	// full hdb3 or b8zs substitution lives outside this block
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_pos_or_data_out_o <= '0;
			rx_neg_or_violation_out_o <= '0;
		end
		else if (!rx_on)
		begin
			// receivers off: outputs held quiet
			rx_pos_or_data_out_o <= '0;
			rx_neg_or_violation_out_o <= '0;
		end
		else
		begin
			for (int i = 0; i < los_mclk_pkg::NCH; i++)
			begin
				if (bit_en[i] && ctrl_r.decode_en)
				begin
					// single rail: data and violation
					rx_pos_or_data_out_o[i] <= s_pos[i] | s_neg[i];
					rx_neg_or_violation_out_o[i] <= s_pos[i] & s_neg[i];
				end
				else if (bit_en[i])
				begin
					// dual rail: pass both rails through
					rx_pos_or_data_out_o[i] <= s_pos[i];
					rx_neg_or_violation_out_o[i] <= s_neg[i];
				end
			end
		end
	end

	// ==========================================================
	// apb decode; every transfer completes with no wait states
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		case (paddr)
			los_mclk_pkg::CTRL_OFS: hit = 1'b1;
			los_mclk_pkg::LOS_OFS: hit = 1'b1;
			los_mclk_pkg::STAT_OFS: hit = 1'b1;
			los_mclk_pkg::MASK_OFS: hit = 1'b1;
			los_mclk_pkg::REF_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// unmapped addresses answer with an error
	assign pslverr = acc && !hit;

	// read mux; bits above each register read as zero
	always_comb
	begin
		prdata = '0;
		if (rd_acc)
		begin
			case (paddr)
				los_mclk_pkg::CTRL_OFS: prdata = 32'(ctrl_r);
				los_mclk_pkg::LOS_OFS: prdata = 32'(loss);
				los_mclk_pkg::STAT_OFS: prdata = 32'(stat_r);
				los_mclk_pkg::MASK_OFS: prdata = 32'(mask_r);
				los_mclk_pkg::REF_OFS: prdata = 32'(ref_edges);
				default: prdata = '0;
			endcase
		end
	end

	// ==========================================================
	// control register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_r <= los_mclk_pkg::CTRL_RST;
		else if (wr_acc && paddr == los_mclk_pkg::CTRL_OFS)
			ctrl_r <= pwdata[$bits(los_mclk_pkg::ctrl_t)-1:0];
	end

	// interrupt enable register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mask_r <= '0;
		else if (wr_acc && paddr == los_mclk_pkg::MASK_OFS)
			mask_r <= pwdata[los_mclk_pkg::NCH-1:0];
	end

	// ==========================================================
	// sticky status: a read or a written one clears, a new event wins
	always_comb
	begin
		stat_nxt = stat_r;
		if (rd_acc && paddr == los_mclk_pkg::STAT_OFS)
			stat_nxt = '0;
		if (wr_acc && paddr == los_mclk_pkg::STAT_OFS)
			stat_nxt = stat_nxt & ~pwdata[los_mclk_pkg::NCH-1:0];
		stat_nxt = stat_nxt | declare;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			stat_r <= '0;
		else
			stat_r <= stat_nxt;
	end

	// ==========================================================
	// active low interrupt, registered so it never glitches
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			int_n_o <= 1'b1;
		else
			int_n_o <= !(|(stat_nxt & mask_r));
	end
endmodule
`default_nettype wire

// ---- verification/front_end_model.sv ----
// model of the analog receive front end feeding all eight channels
`default_nettype none
module front_end_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// line condition from the bench
	input wire logic loss_i,
	input wire logic [3:0] ones_i,
	// recovered stream
	output logic [7:0] rx_clk_o,
	output logic [7:0] rx_pos_o,
	output logic [7:0] rx_neg_o,
	output logic [7:0] analog_loss_o,
	output int bits_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ph_r; // phase inside an eight clock bit
	logic rail_r; // ami polarity of the next mark
	logic mark; // next bit is a one: first ones_i of every eight
	assign mark = {1'b0, bits_o[2:0]} < ones_i;
	// one rate and one stream on every channel, never mixed
	assign rx_clk_o = {8{~ph_r[2]}};
	assign analog_loss_o = {8{loss_i}};
	// data moves at the falling recovered clock, far from the sampling rise
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ph_r <= 3'h0;
			rail_r <= 1'b0;
			bits_o <= 0;
			rx_pos_o <= 8'h00;
			rx_neg_o <= 8'h00;
		end
		else
		begin
			ph_r <= ph_r + 3'h1;
			if (ph_r == 3'h7)
				bits_o <= bits_o + 1;
			if (ph_r == 3'h3)
			begin
				rx_pos_o <= {8{mark & rail_r}};
				rx_neg_o <= {8{mark & ~rail_r}};
				rail_r <= rail_r ^ mark;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/los_mclk_asserts.sv ----
// port level assertion checker for the loss and master clock top
`default_nettype none
module los_mclk_checker
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// pins and results
	input wire logic host_mode_i,
	input wire logic receiver_on_all_i,
	input wire logic [7:0] analog_loss_i,
	input wire logic [7:0] rx_loss_of_signal_o,
	input wire logic [7:0] rx_pos_or_data_out_o,
	input wire logic [7:0] receiver_enable_o,
	input wire logic master_tick_o,
	input wire logic int_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// helper logic
	logic [7:0] mask_r; // interrupt enables as last written on the bus
	logic acc; // apb access phase
	logic mapped; // address hits one of the five words
	assign acc = psel && penable;
	assign mapped = paddr inside {los_mclk_pkg::CTRL_OFS,
		los_mclk_pkg::LOS_OFS, los_mclk_pkg::STAT_OFS,
		los_mclk_pkg::MASK_OFS, los_mclk_pkg::REF_OFS};
	// shadow of the mask, only bus writes move it
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mask_r <= 8'h00;
		else if (acc && pwrite && paddr == los_mclk_pkg::MASK_OFS)
			mask_r <= pwdata[7:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// properties
	a_rx_pin: assert property (
		(!host_mode_i && $stable(receiver_on_all_i))[*4]
		|-> receiver_enable_o == {8{receiver_on_all_i}})
		else $error("receiver enable not from pin");
	a_off_quiet: assert property (
		(receiver_enable_o == 8'h00)[*3] |-> rx_loss_of_signal_o == 8'h00
		&& rx_pos_or_data_out_o == 8'h00)
		else $error("receivers off but outputs active");
	a_loss_irq: assert property (
		(rx_loss_of_signal_o & ~$past(rx_loss_of_signal_o) & mask_r)
		!= 8'h00 |-> ##[0:2] !int_n_o)
		else $error("enabled loss did not pull interrupt low");
	a_read_clear: assert property (
		acc && !pwrite && paddr == los_mclk_pkg::STAT_OFS
		&& $stable(rx_loss_of_signal_o)
		##1 $stable(rx_loss_of_signal_o) |-> int_n_o)
		else $error("interrupt stays low after status read");
	a_bad_addr: assert property (
		acc && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_good_addr: assert property (
		acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_tick_gap: assert property (
		master_tick_o |=> (!master_tick_o)[*8] ##[0:82] master_tick_o)
		else $error("master tick spacing out of range");
	a_loss_cause: assert property (
		$rose(rx_loss_of_signal_o[0]) |-> $past(analog_loss_i[0], 3))
		else $error("loss declared without analog loss");
endmodule
bind rx_los_and_mclk_select los_mclk_checker chk (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.host_mode_i(host_mode_i), .receiver_on_all_i(receiver_on_all_i),
	.analog_loss_i(analog_loss_i),
	.rx_loss_of_signal_o(rx_loss_of_signal_o),
	.rx_pos_or_data_out_o(rx_pos_or_data_out_o),
	.receiver_enable_o(receiver_enable_o),
	.master_tick_o(master_tick_o), .int_n_o(int_n_o));
`default_nettype wire

// ---- verification/rx_los_and_mclk_select_bench.sv ----
// self-checking bench for the loss and master clock top
`default_nettype none
module rx_los_and_mclk_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic host_mode_i, receiver_on_all_i, master_rate_select_i;
	logic [2:0] ref_freq_select_i;
	logic e1_ref, t1_ref, tick, int_n_o, loss, err;
	logic [3:0] ones;
	logic [7:0] rclk, rpos, rneg, aloss, dout, vout, los, rxen;
	logic [15:0] r0;
	int fails, samples_checked, cyc, nbits, tk;
	rx_los_and_mclk_select DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_mode_i(host_mode_i),
		.receiver_on_all_i(receiver_on_all_i),
		.ref_freq_select_i(ref_freq_select_i),
		.master_rate_select_i(master_rate_select_i),
		.e1_ref_clock_in_i(e1_ref), .t1_ref_clock_in_i(t1_ref),
		.rx_clk_i(rclk), .rx_pos_i(rpos), .rx_neg_i(rneg),
		.analog_loss_i(aloss), .rx_pos_or_data_out_o(dout),
		.rx_neg_or_violation_out_o(vout), .rx_loss_of_signal_o(los),
		.receiver_enable_o(rxen), .master_tick_o(tick), .int_n_o(int_n_o));
	front_end_model fe (.clk_i(clk_i), .rst_n_i(rst_n_i), .loss_i(loss),
		.ones_i(ones), .rx_clk_o(rclk), .rx_pos_o(rpos), .rx_neg_o(rneg),
		.analog_loss_o(aloss), .bits_o(nbits));
	// ==========================================================
	// clock, references and watchdog
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// two distinct references, so a wrong pick shows in the edge count
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		e1_ref <= (cyc % 50) < 25;
		t1_ref <= (cyc % 25) < 12;
		if (cyc == 90000)
		begin
			fails++;
			end_sim();
		end
	end
	// ==========================================================
	// tasks
	task automatic end_sim();
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// pass when g lies in e .. e + t; an unknown always fails
	task automatic chk(input string nm, input logic [31:0] e, g, input int t);
		samples_checked++;
		if ((g >= e && g <= e + t) !== 1'b1)
		begin
			$display("BAD %s exp %h got %h", nm, e, g);
			fails++;
		end
	endtask
	// one apb transfer; q and err take the answer at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1)
			@(posedge clk_i);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q, 0);
	endtask
	task automatic wb(input int n);
		int t;
		t = nbits + n;
		while (nbits < t)
			@(posedge clk_i);
	endtask
	// reference edges and master ticks over 1250 clocks
	task automatic meas(input int ee, input int et);
		apb(1'b0, los_mclk_pkg::REF_OFS, 32'h0);
		r0 = q[15:0];
		tk = 0;
		repeat (1250)
		begin
			@(negedge clk_i);
			tk += int'(tick === 1'b1);
		end
		@(posedge clk_i);
		apb(1'b0, los_mclk_pkg::REF_OFS, 32'h0);
		chk("ref edges", 32'(ee - 1), 32'(q[15:0] - r0), 2);
		chk("ticks", 32'(et), 32'(tk), 1);
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{e1_ref, t1_ref, loss, err, q} = '0;
		host_mode_i = 1'b1;
		receiver_on_all_i = 1'b0;
		ref_freq_select_i = 3'h0;
		master_rate_select_i = 1'b0;
		ones = 4'h8;
		fails = 0;
		samples_checked = 0;
		cyc = 0;
		rst_n_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// reset state, unmapped word, host receiver control
		rd("ctrl", los_mclk_pkg::CTRL_OFS, 32'h002);
		rd("los", los_mclk_pkg::LOS_OFS, 32'h0);
		chk("int idle", 1, int_n_o, 0);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped", 1, err, 0);
		chk("rx en host", 8'hFF, rxen, 0);
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h0);
		chk("rx off host", 0, rxen, 0);
		// hardware mode: pins decide receivers, code and rate; the register copies of those are ignored
		host_mode_i <= 1'b0;
		receiver_on_all_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("rx on pin", 8'hFF, rxen, 0);
		receiver_on_all_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("rx off pin", 0, rxen, 0);
		for (int i = 0; i < 16; i++)
		begin
			ref_freq_select_i <= i[2:0];
			master_rate_select_i <= i[3];
			repeat (4) @(posedge clk_i);
			meas(i[2:0] == 3'h1 ? 50 : 25, i[3] ? 15 : 20);
		end
		// host mode: code and rate from the register, pins opposite
		host_mode_i <= 1'b1;
		ref_freq_select_i <= 3'h0;
		master_rate_select_i <= 1'b0;
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h026);
		meas(50, 15);
		// e1 loss after 32 zeros with the interrupt enabled
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h002);
		apb(1'b1, los_mclk_pkg::MASK_OFS, 32'hFF);
		ones <= 4'h0;
		wb(40);
		loss <= 1'b1;
		wb(28);
		chk("e1 early", 0, los, 0);
		wb(12);
		chk("e1 loss", 8'hFF, los, 0);
		chk("int low", 0, int_n_o, 0);
		rd("stat", los_mclk_pkg::STAT_OFS, 32'hFF);
		rd("stat again", los_mclk_pkg::STAT_OFS, 32'h0);
		chk("int high", 1, int_n_o, 0);
		// clear needs analog recovery and density; 1 in 8 is the boundary
		loss <= 1'b0;
		wb(80);
		chk("no density", 8'hFF, los, 0);
		ones <= 4'h1;
		wb(80);
		chk("e1 clear", 0, los, 0);
		// t1: 175 zeros; masked, so the pin stays high
		apb(1'b1, los_mclk_pkg::MASK_OFS, 32'h0);
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h082);
		loss <= 1'b1;
		ones <= 4'h0;
		wb(165);
		chk("t1 early", 0, los, 0);
		wb(20);
		chk("t1 loss", 8'hFF, los, 0);
		chk("int masked", 1, int_n_o, 0);
		rd("t1 stat", los_mclk_pkg::STAT_OFS, 32'hFF);
		loss <= 1'b0;
		ones <= 4'h1;
		wb(300);
		chk("t1 clear", 0, los, 0);
		// extended e1 count
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h042);
		loss <= 1'b1;
		ones <= 4'h0;
		wb(4080);
		chk("ext early", 0, los, 0);
		wb(30);
		chk("ext loss", 8'hFF, los, 0);
		// receivers off reset the detectors
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h100);
		rd("los off", los_mclk_pkg::LOS_OFS, 32'h0);
		// decoder on: a mark on either rail is a one, no violation
		loss <= 1'b0;
		ones <= 4'h8;
		apb(1'b1, los_mclk_pkg::CTRL_OFS, 32'h102);
		wb(20);
		chk("data", 8'hFF, dout, 0);
		chk("violation", 0, vout, 0);
		end_sim();
	end
endmodule
`default_nettype wire
